// [psi_agent_model.sv]
// external agent on the far side of the system interface
`timescale 1ns/10ps
`default_nettype none
module psi_agent_model
	import psi_pkg::*;
(
	// link clock and acceptance commanded by the bench
	input  wire logic                 i_link_clk,
	input  wire logic                 i_rd_ok,
	input  wire logic                 i_wr_ok,
	// agent pins
	output logic                      o_valid_n,
	output logic [PSI_AD_W-1:0]       o_ad,
	output logic [PSI_CHK_W-1:0]      o_chk,
	output logic [PSI_CMD_W-1:0]      o_cmd,
	output logic                      o_par,
	output logic                      o_rd_ready_n,
	output logic                      o_wr_ready_n
);
	initial
	begin
		o_valid_n = 1'b1;
		o_ad = '0;
		o_chk = '0;
		o_cmd = '0;
		o_par = 1'b0;
		o_rd_ready_n = 1'b1;
		o_wr_ready_n = 1'b1;
	end
	always @(posedge i_link_clk)
	begin
		o_rd_ready_n <= !i_rd_ok;
		o_wr_ready_n <= !i_wr_ok;
	end
	function automatic logic [7:0] chk_of(input logic [63:0] d);
		for (int b = 0; b < 8; b++)
			chk_of[b] = ^d[8*b +: 8];
	endfunction
	// released lines show the inverse so stale check bits never match the stale word
	task automatic send(input logic [63:0] d, input logic [8:0] c, input logic bp, input logic bc);
		logic [7:0] k;
		k = chk_of(d) ^ {7'h0, bc};
		@(posedge i_link_clk);
		o_valid_n <= 1'b0;
		o_ad <= d;
		o_chk <= k;
		o_cmd <= c;
		o_par <= (^c) ^ bp;
		@(posedge i_link_clk);
		o_valid_n <= 1'b1;
		o_ad <= ~d;
		o_chk <= ~k;
		o_cmd <= ~c;
		o_par <= ~((^c) ^ bp);
	endtask
endmodule
`default_nettype wire

// [psi_clk_if.sv]
// derived clock bundle between the clock generator and the top
`timescale 1ns/10ps
`default_nettype none
interface psi_clk_if;
	import psi_pkg::*;
	logic [PSI_NCLK-1:0] transmit_clock;
	logic [PSI_NCLK-1:0] receive_clock;
	logic                main_clock_copy;
	logic                running;

	modport gen
	(
		output transmit_clock,
		output receive_clock,
		output main_clock_copy,
		output running
	);
	modport use_clk
	(
		input transmit_clock,
		input receive_clock,
		input main_clock_copy,
		input running
	);
endinterface
`default_nettype wire

// [psi_clkgen.sv]
// transmit, receive and master copy clocks from the master clock
`timescale 1ns/10ps
`default_nettype none
module psi_clkgen
	import psi_pkg::*;
(
	// master clock and released cold reset
	input  wire logic i_mclk,
	input  wire logic i_rst_n,
	// derived clocks
	psi_clk_if.gen    clk_bus
);
	localparam int unsigned CW = (PSI_HALF_DIV > 1) ? $clog2(PSI_HALF_DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(PSI_HALF_DIV - 1);

	logic [CW-1:0] div_cnt;
	logic          phase;

	// everything held low in reset so the first edge follows the release
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			div_cnt <= '0;
			phase   <= 1'b0;
		end
		else if (div_cnt == LAST)
		begin
			div_cnt <= '0;
			phase   <= ~phase;
		end
		else
		begin
			div_cnt <= div_cnt + CW'(1);
		end
	end

	// registered copy toggles on every rising master edge, so it runs at half the master rate
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			clk_bus.main_clock_copy <= 1'b0;
		else
			clk_bus.main_clock_copy <= ~clk_bus.main_clock_copy;
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			clk_bus.running <= 1'b0;
		else
			clk_bus.running <= 1'b1;
	end

	assign clk_bus.transmit_clock = {PSI_NCLK{phase}};
	assign clk_bus.receive_clock  = {PSI_NCLK{phase}};
endmodule
`default_nettype wire

// [psi_pkg.sv]
// shared widths, kinds, states and clock constants of the system interface
package psi_pkg;
	localparam int unsigned PSI_AD_W    = 64;
	localparam int unsigned PSI_CHK_W   = 8;
	localparam int unsigned PSI_CMD_W   = 9;
	localparam int unsigned PSI_BYTE_W  = 8;
	localparam int unsigned PSI_PIN_W   = PSI_AD_W + PSI_CHK_W + PSI_CMD_W + 5;
	localparam int unsigned PSI_NCLK    = 2;

	// master clock 40 ns; link clocks toggle every PSI_HALF_DIV master edges
	localparam int unsigned PSI_MCLK_NS = 40;
	localparam int unsigned PSI_LINK_NS = 80;
	localparam int unsigned PSI_HALF_DIV = PSI_LINK_NS / (2 * PSI_MCLK_NS);

	typedef enum logic [1:0]
	{
		PSI_KIND_READ  = 2'h0,
		PSI_KIND_WRITE = 2'h1,
		PSI_KIND_UPD   = 2'h2,
		PSI_KIND_OTHER = 2'h3
	} psi_kind_t;

	typedef enum logic [1:0]
	{
		PSI_ST_IDLE  = 2'h0,
		PSI_ST_WAIT  = 2'h1,
		PSI_ST_DRIVE = 2'h2,
		PSI_ST_REL   = 2'h3
	} psi_state_t;
endpackage

// [psi_sync.sv]
// two flip-flop synchroniser for a bundle of levels
`timescale 1ns/10ps
`default_nettype none
module psi_sync
#(
	parameter int unsigned WIDTH = 1
)
(
	// clock and reset of the receiving domain
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	// levels
	input  wire logic [WIDTH-1:0] i_d,
	output logic      [WIDTH-1:0] o_q
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			stage1 <= '0;
			o_q    <= '0;
		end
		else
		begin
			stage1 <= i_d;
			o_q    <= stage1;
		end
	end
endmodule
`default_nettype wire

// [psi_top.sv]
// processor end of the multiplexed system interface
// Notes on behaviour
// - one shared 64-bit address/data bus
// - 8 check bits accompany each driven word
// - 9-bit command bus driven with the data
// - parity bit makes command plus parity even
// - processor valid strobe marks every driven word
// - external request line raised when interface needs it
// - release strobe when handing bus back
// - two identical transmit clocks output
// - two identical receive clocks output
// - registered half-rate copy of master clock output
// - derived clocks start at cold reset release
`timescale 1ns/10ps
`default_nettype none
module psi_top
	import psi_pkg::*;
(
	// master clock and cold reset
	input  wire logic                 i_mclk,
	input  wire logic                 i_arst_n,
	// link clock
	input  wire logic                 i_link_clk,
	// core request side
	input  wire logic                 i_req_valid,
	output logic                      o_req_ready,
	input  wire logic [1:0]           i_req_kind,
	input  wire logic [PSI_CMD_W-1:0] i_req_cmd,
	input  wire logic [PSI_AD_W-1:0]  i_req_data,
	input  wire logic                 i_req_release,
	input  wire logic                 i_ext_req_need,
	// core receive side
	output logic                      o_rx_valid,
	output logic [PSI_CMD_W-1:0]      o_rx_cmd,
	output logic [PSI_AD_W-1:0]       o_rx_data,
	output logic                      o_rx_parity_err,
	output logic                      o_rx_check_err,
	// address/data and check pins
	input  wire logic [PSI_AD_W-1:0]  i_sys_addr_data_bus,
	output logic      [PSI_AD_W-1:0]  o_sys_addr_data_bus,
	output logic                      o_sys_addr_data_bus_oe,
	input  wire logic [PSI_CHK_W-1:0] i_sys_check_bits,
	output logic      [PSI_CHK_W-1:0] o_sys_check_bits,
	output logic                      o_sys_check_bits_oe,
	// command and parity pins
	input  wire logic [PSI_CMD_W-1:0] i_sys_command_bus,
	output logic      [PSI_CMD_W-1:0] o_sys_command_bus,
	output logic                      o_sys_command_bus_oe,
	input  wire logic                 i_sys_command_parity,
	output logic                      o_sys_command_parity,
	output logic                      o_sys_command_parity_oe,
	// strobes and flow control
	input  wire logic                 i_agent_valid_n,
	output logic                      o_processor_valid_n,
	output logic                      o_external_request_n,
	output logic                      o_release_n,
	input  wire logic                 i_read_accept_ready_n,
	input  wire logic                 i_write_accept_ready_n,
	// derived clocks
	output logic [PSI_NCLK-1:0]       o_transmit_clock,
	output logic [PSI_NCLK-1:0]       o_receive_clock,
	output logic                      o_main_clock_copy_out
);
	////////////////////////////////////////////////////////////////////////
	function automatic logic [PSI_CHK_W-1:0] check_of(input logic [PSI_AD_W-1:0] w);
		logic [PSI_CHK_W-1:0] c;
		c = '0;
		for (int i = 0; i < PSI_CHK_W; i++)
			c[i] = ^w[i*PSI_BYTE_W +: PSI_BYTE_W];
		return c;
	endfunction

	function automatic logic parity_of(input logic [PSI_CMD_W-1:0] c);
		return ^c;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// reset release in both domains
	logic [1:0] mrst_sr;
	logic       mrst_n;
	logic [1:0] lrst_sr;
	logic       lrst_n;

	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			mrst_sr <= 2'h0;
		else
			mrst_sr <= {mrst_sr[0], 1'b1};
	end
	assign mrst_n = mrst_sr[1];

	always_ff @(posedge i_link_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			lrst_sr <= 2'h0;
		else
			lrst_sr <= {lrst_sr[0], 1'b1};
	end
	assign lrst_n = lrst_sr[1];

	////////////////////////////////////////////////////////////////////////
	// derived clocks
	psi_clk_if clk_bus ();

	psi_clkgen u_clkgen
	(
		.i_mclk  (i_mclk),
		.i_rst_n (mrst_n),
		.clk_bus (clk_bus.gen)
	);

	always_ff @(posedge i_mclk or negedge mrst_n)
	begin
		if (!mrst_n)
		begin
			o_transmit_clock      <= '0;
			o_receive_clock       <= '0;
			o_main_clock_copy_out <= 1'b0;
		end
		else
		begin
			o_transmit_clock      <= clk_bus.transmit_clock;
			o_receive_clock       <= clk_bus.receive_clock;
			o_main_clock_copy_out <= clk_bus.main_clock_copy;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// core domain request holding, toggle handshake to the link
	logic                 busy;
	logic                 req_tgl;
	logic [1:0]           hold_kind;
	logic [PSI_CMD_W-1:0] hold_cmd;
	logic [PSI_AD_W-1:0]  hold_data;
	logic                 hold_rel;
	logic                 ack_tgl;
	logic                 ack_tgl_m;
	logic                 ack_seen;

	psi_sync #(.WIDTH(1)) u_ack_sync
	(
		.i_clk   (i_mclk),
		.i_rst_n (mrst_n),
		.i_d     (ack_tgl),
		.o_q     (ack_tgl_m)
	);

	// payload frozen while busy so the link may read it without a crossing
	always_ff @(posedge i_mclk or negedge mrst_n)
	begin
		if (!mrst_n)
		begin
			busy      <= 1'b0;
			req_tgl   <= 1'b0;
			ack_seen  <= 1'b0;
			hold_kind <= PSI_KIND_OTHER;
			hold_cmd  <= '0;
			hold_data <= '0;
			hold_rel  <= 1'b0;
			// ready held low until this domain is out of reset
			o_req_ready <= 1'b0;
		end
		else if (o_req_ready && i_req_valid)
		begin
			busy      <= 1'b1;
			req_tgl   <= ~req_tgl;
			hold_kind <= i_req_kind;
			hold_cmd  <= i_req_cmd;
			hold_data <= i_req_data;
			hold_rel  <= i_req_release;
			o_req_ready <= 1'b0;
		end
		else if (busy && (ack_tgl_m != ack_seen))
		begin
			busy        <= 1'b0;
			ack_seen    <= ack_tgl_m;
			o_req_ready <= 1'b1;
		end
		else
		begin
			o_req_ready <= ~busy;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link domain: pin inputs pass two flops, all aligned together
	logic [PSI_PIN_W-1:0] pin_q;
	logic [PSI_AD_W-1:0]  in_ad;
	logic [PSI_CHK_W-1:0] in_chk;
	logic [PSI_CMD_W-1:0] in_cmd;
	logic                 in_par;
	logic                 in_valid_n;
	logic                 in_rd_rdy_n;
	logic                 in_wr_rdy_n;
	logic                 in_need;
	logic                 req_tgl_l;

	psi_sync #(.WIDTH(PSI_PIN_W)) u_pin_sync
	(
		.i_clk   (i_link_clk),
		.i_rst_n (lrst_n),
		.i_d     ({i_sys_addr_data_bus, i_sys_check_bits, i_sys_command_bus,
			i_sys_command_parity, i_agent_valid_n, i_read_accept_ready_n,
			i_write_accept_ready_n, i_ext_req_need}),
		.o_q     (pin_q)
	);
	assign {in_ad, in_chk, in_cmd, in_par, in_valid_n, in_rd_rdy_n, in_wr_rdy_n,
		in_need} = pin_q;

	psi_sync #(.WIDTH(1)) u_req_sync
	(
		.i_clk   (i_link_clk),
		.i_rst_n (lrst_n),
		.i_d     (req_tgl),
		.o_q     (req_tgl_l)
	);

	////////////////////////////////////////////////////////////////////////
	// link domain transmit sequencer
	psi_state_t state;
	psi_state_t next_state;
	logic       req_seen;
	logic       ready_ok;

	always_comb
	begin
		case (psi_kind_t'(hold_kind))
			PSI_KIND_READ:  ready_ok = ~in_rd_rdy_n;
			PSI_KIND_UPD:   ready_ok = ~in_rd_rdy_n;
			PSI_KIND_WRITE: ready_ok = ~in_wr_rdy_n;
			default:        ready_ok = 1'b1;
		endcase
	end

	always_comb
	begin
		next_state = state;
		case (state)
			PSI_ST_IDLE:
				if (req_tgl_l != req_seen)
					next_state = PSI_ST_WAIT;
			PSI_ST_WAIT:
				if (ready_ok && in_valid_n)
					next_state = PSI_ST_DRIVE;
			PSI_ST_DRIVE:
				next_state = hold_rel ? PSI_ST_REL : PSI_ST_IDLE;
			PSI_ST_REL:
				next_state = PSI_ST_IDLE;
			default:
				next_state = PSI_ST_IDLE;
		endcase
	end

	always_ff @(posedge i_link_clk or negedge lrst_n)
	begin
		if (!lrst_n)
			state <= PSI_ST_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge i_link_clk or negedge lrst_n)
	begin
		if (!lrst_n)
		begin
			req_seen <= 1'b0;
			ack_tgl  <= 1'b0;
		end
		else if (state == PSI_ST_IDLE && req_tgl_l != req_seen)
		begin
			req_seen <= req_tgl_l;
		end
		else if (next_state == PSI_ST_IDLE && state != PSI_ST_IDLE)
		begin
			ack_tgl <= ~ack_tgl;
		end
	end

	// word, check, command and parity all driven in the one valid cycle
	always_ff @(posedge i_link_clk or negedge lrst_n)
	begin
		if (!lrst_n)
		begin
			o_sys_addr_data_bus     <= '0;
			o_sys_check_bits        <= '0;
			o_sys_command_bus       <= '0;
			o_sys_command_parity    <= 1'b0;
			o_sys_addr_data_bus_oe  <= 1'b0;
			o_sys_check_bits_oe     <= 1'b0;
			o_sys_command_bus_oe    <= 1'b0;
			o_sys_command_parity_oe <= 1'b0;
			o_processor_valid_n     <= 1'b1;
		end
		else
		begin
			o_sys_addr_data_bus     <= hold_data;
			o_sys_check_bits        <= check_of(hold_data);
			o_sys_command_bus       <= hold_cmd;
			o_sys_command_parity    <= parity_of(hold_cmd);
			o_sys_addr_data_bus_oe  <= (next_state == PSI_ST_DRIVE);
			o_sys_check_bits_oe     <= (next_state == PSI_ST_DRIVE);
			o_sys_command_bus_oe    <= (next_state == PSI_ST_DRIVE);
			o_sys_command_parity_oe <= (next_state == PSI_ST_DRIVE);
			o_processor_valid_n     <= ~(next_state == PSI_ST_DRIVE);
		end
	end

	always_ff @(posedge i_link_clk or negedge lrst_n)
	begin
		if (!lrst_n)
		begin
			o_release_n          <= 1'b1;
			o_external_request_n <= 1'b1;
		end
		else
		begin
			o_release_n          <= ~(next_state == PSI_ST_REL);
			o_external_request_n <= ~in_need;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link domain receive capture; words arriving while one is pending drop
	logic                 rx_pend;
	logic                 rx_tgl;
	logic                 rx_ack_l;
	logic                 rx_ack_tgl;
	logic [PSI_AD_W-1:0]  rx_ad;
	logic [PSI_CMD_W-1:0] rx_cmd;
	logic                 rx_perr;
	logic                 rx_cerr;

	psi_sync #(.WIDTH(1)) u_rxack_sync
	(
		.i_clk   (i_link_clk),
		.i_rst_n (lrst_n),
		.i_d     (rx_ack_tgl),
		.o_q     (rx_ack_l)
	);

	always_ff @(posedge i_link_clk or negedge lrst_n)
	begin
		if (!lrst_n)
		begin
			rx_pend <= 1'b0;
			rx_tgl  <= 1'b0;
			rx_ad   <= '0;
			rx_cmd  <= '0;
			rx_perr <= 1'b0;
			rx_cerr <= 1'b0;
		end
		else if (!rx_pend && !in_valid_n && !o_sys_addr_data_bus_oe)
		begin
			rx_pend <= 1'b1;
			rx_tgl  <= ~rx_tgl;
			rx_ad   <= in_ad;
			rx_cmd  <= in_cmd;
			rx_perr <= parity_of(in_cmd) ^ in_par;
			rx_cerr <= (check_of(in_ad) != in_chk);
		end
		else if (rx_pend && (rx_ack_l == rx_tgl))
		begin
			rx_pend <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// core domain receive delivery
	logic rx_tgl_m;

	psi_sync #(.WIDTH(1)) u_rx_sync
	(
		.i_clk   (i_mclk),
		.i_rst_n (mrst_n),
		.i_d     (rx_tgl),
		.o_q     (rx_tgl_m)
	);

	// rx fields are stable from the toggle until the ack returns
	always_ff @(posedge i_mclk or negedge mrst_n)
	begin
		if (!mrst_n)
		begin
			rx_ack_tgl      <= 1'b0;
			o_rx_valid      <= 1'b0;
			o_rx_cmd        <= '0;
			o_rx_data       <= '0;
			o_rx_parity_err <= 1'b0;
			o_rx_check_err  <= 1'b0;
		end
		else
		begin
			o_rx_valid <= (rx_tgl_m != rx_ack_tgl);
			if (rx_tgl_m != rx_ack_tgl)
			begin
				rx_ack_tgl      <= rx_tgl_m;
				o_rx_cmd        <= rx_cmd;
				o_rx_data       <= rx_ad;
				o_rx_parity_err <= rx_perr;
				o_rx_check_err  <= rx_cerr;
			end
		end
	end
endmodule
`default_nettype wire

// [psi_top_chk.sv]
// assertions on the pins of the processor end of the system interface
`timescale 1ns/10ps
`default_nettype none
module psi_top_chk
	import psi_pkg::*;
(
	// clocks, reset and request line
	input wire logic                 i_mclk,
	input wire logic                 i_arst_n,
	input wire logic                 i_link_clk,
	input wire logic                 i_ext_req_need,
	// pins driven by the design
	input wire logic [PSI_AD_W-1:0]  o_sys_addr_data_bus,
	input wire logic                 o_sys_addr_data_bus_oe,
	input wire logic                 o_sys_check_bits_oe,
	input wire logic                 o_sys_command_parity_oe,
	input wire logic [PSI_CHK_W-1:0] o_sys_check_bits,
	input wire logic [PSI_CMD_W-1:0] o_sys_command_bus,
	input wire logic                 o_sys_command_bus_oe,
	input wire logic                 o_sys_command_parity,
	input wire logic                 o_processor_valid_n,
	input wire logic                 o_external_request_n,
	input wire logic                 o_release_n,
	input wire logic [PSI_NCLK-1:0]  o_transmit_clock,
	input wire logic [PSI_NCLK-1:0]  o_receive_clock,
	input wire logic                 o_main_clock_copy_out
);
	logic [3:0] mcnt;
	logic [3:0] lcnt;
	////////////////////////////////////////////////////////////////
	// edges since reset release, saturating
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			mcnt <= 4'h0;
		else if (mcnt != 4'hf)
			mcnt <= mcnt + 4'h1;
	end
	always_ff @(posedge i_link_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			lcnt <= 4'h0;
		else if (lcnt != 4'hf)
			lcnt <= lcnt + 4'h1;
	end
	function automatic logic [7:0] chk_of(input logic [63:0] d);
		for (int b = 0; b < 8; b++)
			chk_of[b] = ^d[8*b +: 8];
	endfunction
	////////////////////////////////////////////////////////////////
	sequence s_word;
		!o_processor_valid_n;
	endsequence
	sequence s_rel;
		!o_release_n ##1 o_release_n;
	endsequence
	property p_drive;
		@(posedge i_link_clk) disable iff (!i_arst_n)
		s_word |-> o_sys_addr_data_bus_oe && o_sys_command_bus_oe
			&& o_sys_check_bits_oe && o_sys_command_parity_oe;
	endproperty
	a_drive: assert property (p_drive)
		else $error("word strobed without driving the bus");
	property p_oe;
		@(posedge i_link_clk) disable iff (!i_arst_n)
		(o_sys_addr_data_bus_oe || o_sys_command_bus_oe) |-> s_word;
	endproperty
	a_oe: assert property (p_oe)
		else $error("bus driven without valid strobe");
	property p_par;
		@(posedge i_link_clk) disable iff (!i_arst_n)
		s_word |-> (^{o_sys_command_bus, o_sys_command_parity}) == 1'b0;
	endproperty
	a_par: assert property (p_par)
		else $error("command parity not even");
	property p_chk;
		@(posedge i_link_clk) disable iff (!i_arst_n)
		s_word |-> o_sys_check_bits == chk_of(o_sys_addr_data_bus);
	endproperty
	a_chk: assert property (p_chk)
		else $error("check bits do not match word");
	property p_vpulse;
		@(posedge i_link_clk) disable iff (!i_arst_n)
		s_word |=> o_processor_valid_n;
	endproperty
	a_vpulse: assert property (p_vpulse)
		else $error("valid strobe longer than one cycle");
	property p_rel;
		@(posedge i_link_clk) disable iff (!i_arst_n)
		$fell(o_release_n) |-> !$past(o_processor_valid_n) ##0 s_rel;
	endproperty
	a_rel: assert property (p_rel)
		else $error("release not one cycle after a word");
	property p_ext;
		@(posedge i_link_clk) disable iff (!i_arst_n)
		(lcnt > 4'h3 && i_ext_req_need) [*4] |-> !o_external_request_n;
	endproperty
	a_ext: assert property (p_ext)
		else $error("external request not raised");
	property p_tx;
		@(posedge i_mclk) disable iff (!i_arst_n)
		o_transmit_clock[0] == o_transmit_clock[1];
	endproperty
	a_tx: assert property (p_tx)
		else $error("transmit clocks differ");
	property p_rx;
		@(posedge i_mclk) disable iff (!i_arst_n)
		o_receive_clock[0] == o_receive_clock[1];
	endproperty
	a_rx: assert property (p_rx)
		else $error("receive clocks differ");
	property p_quiet;
		@(posedge i_mclk) disable iff (!i_arst_n)
		mcnt <= 4'h2 |-> o_transmit_clock == '0 && o_receive_clock == '0;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("derived clocks ran before reset release");
	property p_run;
		@(posedge i_mclk) disable iff (!i_arst_n)
		mcnt >= 4'h6 |-> $changed(o_transmit_clock[0]) && $changed(o_main_clock_copy_out);
	endproperty
	a_run: assert property (p_run)
		else $error("derived clocks not running");
endmodule
`default_nettype wire

// [test_processor_system_interface.sv]
// self-checking bench for the processor end of the system interface
`timescale 1ns/10ps
`default_nettype none
module test_processor_system_interface;
	import psi_pkg::*;
	logic i_mclk = 1'b0, i_link_clk = 1'b0, i_arst_n = 1'b0;
	logic i_req_valid = 1'b0, i_req_release = 1'b0, i_ext_req_need = 1'b0;
	logic [1:0] i_req_kind = 2'h0;
	logic [8:0] i_req_cmd = 9'h0;
	logic [63:0] i_req_data = 64'h0;
	logic rd_ok = 1'b0, wr_ok = 1'b0;
	logic o_req_ready, o_rx_valid, o_rx_parity_err, o_rx_check_err, o_processor_valid_n;
	logic o_external_request_n, o_release_n, o_main_clock_copy_out;
	logic o_sys_addr_data_bus_oe, o_sys_check_bits_oe, o_sys_command_bus_oe;
	logic o_sys_command_parity, o_sys_command_parity_oe, a_par, i_sys_command_parity;
	logic [8:0] o_rx_cmd, o_sys_command_bus, a_cmd, i_sys_command_bus, tx_c;
	logic [63:0] o_rx_data, o_sys_addr_data_bus, a_ad, i_sys_addr_data_bus, tx_d;
	logic [7:0] o_sys_check_bits, a_chk, i_sys_check_bits, tx_k;
	logic [1:0] o_transmit_clock, o_receive_clock;
	wire i_agent_valid_n, i_read_accept_ready_n, i_write_accept_ready_n;
	int seed = 32'h42ba, bad_count = 0, samples_checked = 0, tx_n = 0, rel_n = 0, rx_n = 0;
	logic tx_p;
	////////////////////////////////////////////////////////////////
	assign i_sys_addr_data_bus = o_sys_addr_data_bus_oe ? o_sys_addr_data_bus : a_ad;
	assign i_sys_check_bits = o_sys_check_bits_oe ? o_sys_check_bits : a_chk;
	assign i_sys_command_bus = o_sys_command_bus_oe ? o_sys_command_bus : a_cmd;
	assign i_sys_command_parity = o_sys_command_parity_oe ? o_sys_command_parity : a_par;
	psi_top dut
	(
		.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_link_clk(i_link_clk),
		.i_req_valid(i_req_valid), .o_req_ready(o_req_ready), .i_req_kind(i_req_kind),
		.i_req_cmd(i_req_cmd), .i_req_data(i_req_data), .i_req_release(i_req_release),
		.i_ext_req_need(i_ext_req_need), .o_rx_valid(o_rx_valid), .o_rx_cmd(o_rx_cmd),
		.o_rx_data(o_rx_data), .o_rx_parity_err(o_rx_parity_err),
		.o_rx_check_err(o_rx_check_err),
		.i_sys_addr_data_bus(i_sys_addr_data_bus),
		.o_sys_addr_data_bus(o_sys_addr_data_bus),
		.o_sys_addr_data_bus_oe(o_sys_addr_data_bus_oe),
		.i_sys_check_bits(i_sys_check_bits), .o_sys_check_bits(o_sys_check_bits),
		.o_sys_check_bits_oe(o_sys_check_bits_oe),
		.i_sys_command_bus(i_sys_command_bus), .o_sys_command_bus(o_sys_command_bus),
		.o_sys_command_bus_oe(o_sys_command_bus_oe),
		.i_sys_command_parity(i_sys_command_parity),
		.o_sys_command_parity(o_sys_command_parity),
		.o_sys_command_parity_oe(o_sys_command_parity_oe),
		.i_agent_valid_n(i_agent_valid_n), .o_processor_valid_n(o_processor_valid_n),
		.o_external_request_n(o_external_request_n), .o_release_n(o_release_n),
		.i_read_accept_ready_n(i_read_accept_ready_n),
		.i_write_accept_ready_n(i_write_accept_ready_n),
		.o_transmit_clock(o_transmit_clock), .o_receive_clock(o_receive_clock),
		.o_main_clock_copy_out(o_main_clock_copy_out)
	);
	psi_agent_model agt (.i_link_clk(i_link_clk), .i_rd_ok(rd_ok), .i_wr_ok(wr_ok),
		.o_valid_n(i_agent_valid_n), .o_ad(a_ad), .o_chk(a_chk), .o_cmd(a_cmd),
		.o_par(a_par), .o_rd_ready_n(i_read_accept_ready_n),
		.o_wr_ready_n(i_write_accept_ready_n));
	always #20 i_mclk = ~i_mclk;
	initial
	begin
		#13;
		forever #62.5 i_link_clk = ~i_link_clk;
	end
	always @(posedge i_link_clk)
	begin
		if (o_processor_valid_n === 1'b0)
		begin
			tx_n++;
			{tx_d, tx_c, tx_p, tx_k} = {o_sys_addr_data_bus, o_sys_command_bus,
				o_sys_command_parity, o_sys_check_bits};
		end
		if (o_release_n === 1'b0)
			rel_n++;
	end
	always @(posedge i_mclk)
		if (o_rx_valid === 1'b1)
			rx_n++;
	////////////////////////////////////////////////////////////////
	task automatic cmp_word(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_flag(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		if (bad_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// only the wrong readiness first: nothing may leave until the right one
	task automatic issue(input int k, input logic rel);
		int n, t0, r0;
		logic [63:0] d;
		logic [8:0] c;
		d = {$random(seed), $random(seed)};
		c = 9'($random(seed));
		for (n = 0; n < 2000 && o_req_ready !== 1'b1; n++)
			@(negedge i_mclk);
		t0 = tx_n;
		r0 = rel_n;
		@(posedge i_mclk);
		{i_req_valid, i_req_kind, i_req_cmd, i_req_data, i_req_release} <= {1'b1, 2'(k), c, d, rel};
		rd_ok <= (k == 1);
		wr_ok <= (k != 1);
		@(posedge i_mclk);
		i_req_valid <= 1'b0;
		repeat (12) @(posedge i_link_clk);
		cmp_word(64'(tx_n - t0), 64'h0);
		cmp_flag(o_req_ready, 1'b0);
		@(posedge i_mclk);
		rd_ok <= (k != 1);
		wr_ok <= (k == 1);
		for (n = 0; n < 200 && tx_n == t0; n++)
			@(posedge i_link_clk);
		repeat (3) @(posedge i_link_clk);
		cmp_word(tx_d, d);
		cmp_word({55'h0, tx_c}, {55'h0, c});
		cmp_flag(^{tx_c, tx_p}, 1'b0);
		cmp_word({56'h0, tx_k}, {56'h0, agt.chk_of(d)});
		cmp_word(64'(rel_n - r0), 64'(rel));
		@(posedge i_mclk);
		{rd_ok, wr_ok} <= 2'h0;
	endtask
	task automatic recv(input logic bp, input logic bc);
		int n, r0;
		logic [63:0] d;
		logic [8:0] c;
		d = {$random(seed), $random(seed)};
		c = 9'($random(seed));
		r0 = rx_n;
		agt.send(d, c, bp, bc);
		for (n = 0; n < 100 && rx_n == r0; n++)
			@(negedge i_mclk);
		cmp_word(o_rx_data, d);
		cmp_word({55'h0, o_rx_cmd}, {55'h0, c});
		cmp_flag(o_rx_parity_err, bp);
		cmp_flag(o_rx_check_err, bc);
		repeat (8) @(posedge i_link_clk);
		cmp_word(64'(rx_n - r0), 64'h1);
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge i_mclk);
		i_arst_n <= 1'b1;
		repeat (8) @(posedge i_link_clk);
		@(posedge i_mclk);
		i_ext_req_need <= 1'b1;
		repeat (6) @(posedge i_link_clk);
		cmp_flag(o_external_request_n, 1'b0);
		@(posedge i_mclk);
		i_ext_req_need <= 1'b0;
		repeat (6) @(posedge i_link_clk);
		cmp_flag(o_external_request_n, 1'b1);
		for (int k = 0; k < 3; k++)
			issue(k, 1'b1);
		recv(1'b1, 1'b0);
		recv(1'b0, 1'b1);
		repeat (16)
		begin
			issue($unsigned($random(seed)) % 3, 1'($random(seed)));
			recv(1'b0, 1'b0);
		end
		end_of_test;
	end
	initial
	begin
		#2000000;
		bad_count++;
		end_of_test;
	end
endmodule
bind psi_top psi_top_chk chk
(
	.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_link_clk(i_link_clk),
	.i_ext_req_need(i_ext_req_need),
	.o_sys_addr_data_bus(o_sys_addr_data_bus),
	.o_sys_addr_data_bus_oe(o_sys_addr_data_bus_oe),
	.o_sys_check_bits_oe(o_sys_check_bits_oe),
	.o_sys_command_parity_oe(o_sys_command_parity_oe),
	.o_sys_check_bits(o_sys_check_bits), .o_sys_command_bus(o_sys_command_bus),
	.o_sys_command_bus_oe(o_sys_command_bus_oe),
	.o_sys_command_parity(o_sys_command_parity),
	.o_processor_valid_n(o_processor_valid_n),
	.o_external_request_n(o_external_request_n), .o_release_n(o_release_n),
	.o_transmit_clock(o_transmit_clock), .o_receive_clock(o_receive_clock),
	.o_main_clock_copy_out(o_main_clock_copy_out)
);
`default_nettype wire
